//--- core/bst_tap.sv
/*
  Reduced boundary-scan test access port of a synchronous memory:
  state machine, instruction register, bypass, identification and
  boundary registers, serial output on the falling test-clock edge.
  Assumes tck, tms and tdi come from an external test controller,
  tms and tdi pulled up at the pad, and tdo resolved from tdo_oe.
*/
`timescale 1ns/1ps

// How it works
// - all port inputs sampled on rising tck
// - serial output changes on falling tck only
// - mode select pulled up, floats to high
// - serial input enters register MSB, pulled up
// - serial output shows selected register LSB
// - output driven only in shift states
// - one register in path, chosen by instruction
// - five high mode-select edges reach reset
// - port reset leaves memory operation alone
// - port resets itself at power-up, output off
// - three-bit instruction loaded serially in shift
// - identification instruction after power-up and reset
// - instruction capture loads binary 01 low bits
// - one-bit bypass, cleared on data-register capture
// - identification capture loads fixed 32-bit word
// - all-zero code samples and floats memory outputs
// - sample-z routes boundary register, floats outputs
// - bypass instruction routes through single bypass bit

module bst_tap
  import bst_pkg::*;
#(
  parameter int unsigned BSR_LEN = BST_BSR_LEN_DEF,
  parameter logic [BST_ID_LEN-1:0] ID_WORD = BST_ID_DEF
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [BSR_LEN-1:0] pin_state,
  output logic mem_hiz,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  generate
    if (BSR_LEN < 2)
    begin : g_bad_len
      $error("boundary register needs at least two bits");
    end
  endgenerate

  // ************************************************************
  // instruction decode
  // ************************************************************

  // which data register an instruction places in the path
  function automatic bst_dr_t route(input logic [2:0] op);
    bst_dr_t r;
    r = BST_DR_BYP;
    case (op)
      BST_OP_IDCODE: r = BST_DR_ID;
      BST_OP_EXTEST: r = BST_DR_BSR;
      BST_OP_SAMPLE_Z: r = BST_DR_BSR;
      BST_OP_SAMPLE: r = BST_DR_BSR;
      BST_OP_BYPASS: r = BST_DR_BYP;
      default: r = BST_DR_BYP;
    endcase
    return r;
  endfunction : route

  // whether an instruction floats the memory outputs
  function automatic logic floats(input logic [2:0] op);
    logic f;
    f = (op == BST_OP_EXTEST) || (op == BST_OP_SAMPLE_Z);
    return f;
  endfunction : floats

  // ************************************************************
  // controller state machine
  // ************************************************************
  bst_state_t state;
  bst_state_t next_state;

  // next state from the sampled mode select
  always_comb
  begin
    next_state = state;
    case (state)
      BST_ST_RESET: next_state = tms ? BST_ST_RESET : BST_ST_IDLE;
      BST_ST_IDLE: next_state = tms ? BST_ST_SEL_DR : BST_ST_IDLE;
      BST_ST_SEL_DR: next_state = tms ? BST_ST_SEL_IR : BST_ST_CAP_DR;
      BST_ST_CAP_DR: next_state = tms ? BST_ST_EXIT1_DR : BST_ST_SHIFT_DR;
      BST_ST_SHIFT_DR: next_state = tms ? BST_ST_EXIT1_DR : BST_ST_SHIFT_DR;
      BST_ST_EXIT1_DR: next_state = tms ? BST_ST_UPD_DR : BST_ST_PAUSE_DR;
      BST_ST_PAUSE_DR: next_state = tms ? BST_ST_EXIT2_DR : BST_ST_PAUSE_DR;
      BST_ST_EXIT2_DR: next_state = tms ? BST_ST_UPD_DR : BST_ST_SHIFT_DR;
      BST_ST_UPD_DR: next_state = tms ? BST_ST_SEL_DR : BST_ST_IDLE;
      BST_ST_SEL_IR: next_state = tms ? BST_ST_RESET : BST_ST_CAP_IR;
      BST_ST_CAP_IR: next_state = tms ? BST_ST_EXIT1_IR : BST_ST_SHIFT_IR;
      BST_ST_SHIFT_IR: next_state = tms ? BST_ST_EXIT1_IR : BST_ST_SHIFT_IR;
      BST_ST_EXIT1_IR: next_state = tms ? BST_ST_UPD_IR : BST_ST_PAUSE_IR;
      BST_ST_PAUSE_IR: next_state = tms ? BST_ST_EXIT2_IR : BST_ST_PAUSE_IR;
      BST_ST_EXIT2_IR: next_state = tms ? BST_ST_UPD_IR : BST_ST_SHIFT_IR;
      BST_ST_UPD_IR: next_state = tms ? BST_ST_SEL_DR : BST_ST_IDLE;
      default: next_state = BST_ST_RESET;
    endcase
  end

  // the floating pin reads high, so an idle port falls into reset;
  // any path with tms high for five edges lands in reset
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= BST_ST_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ************************************************************
  // instruction register
  // ************************************************************
  logic [2:0] ir;
  logic [2:0] ir_sr;

  // instruction shifter: capture pattern, then shift toward lsb
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      ir_sr <= BST_IR_CAPTURE;
    end
    else if (state == BST_ST_CAP_IR)
    begin
      ir_sr <= BST_IR_CAPTURE;
    end
    else if (state == BST_ST_SHIFT_IR)
    begin
      ir_sr <= {tdi, ir_sr[2:1]};
    end
  end

  // held instruction: loaded on update, forced in reset
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      ir <= BST_IR_RESET;
    end
    else if (state == BST_ST_RESET)
    begin
      ir <= BST_IR_RESET;
    end
    else if (state == BST_ST_UPD_IR)
    begin
      ir <= ir_sr;
    end
  end

  bst_dr_t dr_sel;

  // data register picked by the held instruction
  assign dr_sel = route(ir);

  // ************************************************************
  // data registers
  // ************************************************************
  logic byp;
  logic [BST_ID_LEN-1:0] id_sr;
  logic [BSR_LEN-1:0] bsr_sr;
  logic cap_dr;
  logic sh_dr;

  assign cap_dr = (state == BST_ST_CAP_DR);
  assign sh_dr = (state == BST_ST_SHIFT_DR);

  // single bypass bit, cleared on capture
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      byp <= BST_BYP_CAPTURE;
    end
    else if (dr_sel == BST_DR_BYP)
    begin
      if (cap_dr)
      begin
        byp <= BST_BYP_CAPTURE;
      end
      else if (sh_dr)
      begin
        byp <= tdi;
      end
    end
  end

  // identification shifter with the fixed word on capture
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      id_sr <= '0;
    end
    else if (dr_sel == BST_DR_ID)
    begin
      if (cap_dr)
      begin
        id_sr <= ID_WORD;
      end
      else if (sh_dr)
      begin
        id_sr <= {tdi, id_sr[BST_ID_LEN-1:1]};
      end
    end
  end

  bst_cap_if #(.W(BSR_LEN)) cap ();

  // pin words cross from the memory clock by handshake
  bst_snap #(.W(BSR_LEN)) u_snap
  (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .tck(tck),
    .pin_state(pin_state),
    .cap(cap.src)
  );

  // boundary shifter: snapshot on capture, no preload on update
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      bsr_sr <= '0;
    end
    else if (dr_sel == BST_DR_BSR)
    begin
      if (cap_dr)
      begin
        bsr_sr <= cap.word;
      end
      else if (sh_dr)
      begin
        bsr_sr <= {tdi, bsr_sr[BSR_LEN-1:1]};
      end
    end
  end

  // ************************************************************
  // serial output
  // ************************************************************
  logic out_bit;
  logic out_en;

  // lsb of the one register in the path
  always_comb
  begin
    out_bit = byp;
    if (state == BST_ST_SHIFT_IR)
    begin
      out_bit = ir_sr[0];
    end
    else if (dr_sel == BST_DR_ID)
    begin
      out_bit = id_sr[0];
    end
    else if (dr_sel == BST_DR_BSR)
    begin
      out_bit = bsr_sr[0];
    end
  end

  // driver is on only while a register shifts; the pad floats
  // the pin otherwise, so a shared board chain sees no contention
  assign out_en = (state == BST_ST_SHIFT_IR) || sh_dr;

  // launched on the falling edge, half a period before sampling
  always_ff @(negedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end
    else
    begin
      tdo <= out_bit;
      tdo_oe <= out_en;
    end
  end

  // ************************************************************
  // memory output float control
  // ************************************************************
  logic hiz_tck;
  logic hiz_s1;

  // level follows the held instruction only, never the fsm,
  // so a port reset does not upset memory accesses
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      hiz_tck <= 1'h0;
    end
    else
    begin
      hiz_tck <= floats(ir);
    end
  end

  // two-flop crossing into the memory clock
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hiz_s1 <= 1'h0;
      mem_hiz <= 1'h0;
    end
    else if (ce)
    begin
      hiz_s1 <= hiz_tck;
      mem_hiz <= hiz_s1;
    end
  end

endmodule : bst_tap

//--- shared/bst_pkg.sv
/*
  Constants and types for the reduced boundary-scan test port.
  Assumes nothing of its surroundings; imported by both core files.
*/
package bst_pkg;

  // ************************************************************
  // register lengths
  // ************************************************************
  localparam int unsigned BST_IR_LEN = 3;
  localparam int unsigned BST_ID_LEN = 32;
  localparam int unsigned BST_BSR_LEN_DEF = 16;

  // ************************************************************
  // instruction codes
  // ************************************************************
  localparam logic [2:0] BST_OP_EXTEST = 3'h0;
  localparam logic [2:0] BST_OP_IDCODE = 3'h1;
  localparam logic [2:0] BST_OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] BST_OP_RSVD_A = 3'h3;
  localparam logic [2:0] BST_OP_SAMPLE = 3'h4;
  localparam logic [2:0] BST_OP_RSVD_B = 3'h5;
  localparam logic [2:0] BST_OP_RSVD_C = 3'h6;
  localparam logic [2:0] BST_OP_BYPASS = 3'h7;

  // pattern loaded into the instruction shifter on capture
  localparam logic [2:0] BST_IR_CAPTURE = 3'h1;
  // instruction held after power-up and in test-logic-reset
  localparam logic [2:0] BST_IR_RESET = BST_OP_IDCODE;
  // value loaded into the bypass bit on capture
  localparam logic BST_BYP_CAPTURE = 1'h0;

  // identification word; value is arbitrary
  localparam logic [31:0] BST_ID_DEF = 32'h0000_0001;

  // consecutive high mode-select edges that reach reset
  localparam int unsigned BST_RESET_TMS_EDGES = 5;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0]
  {
    BST_ST_RESET, BST_ST_IDLE,
    BST_ST_SEL_DR, BST_ST_CAP_DR, BST_ST_SHIFT_DR, BST_ST_EXIT1_DR,
    BST_ST_PAUSE_DR, BST_ST_EXIT2_DR, BST_ST_UPD_DR,
    BST_ST_SEL_IR, BST_ST_CAP_IR, BST_ST_SHIFT_IR, BST_ST_EXIT1_IR,
    BST_ST_PAUSE_IR, BST_ST_EXIT2_IR, BST_ST_UPD_IR
  } bst_state_t;

  typedef enum logic [1:0]
  {
    BST_DR_BYP, BST_DR_ID, BST_DR_BSR
  } bst_dr_t;

endpackage : bst_pkg

//--- shared/bst_cap_if.sv
/*
  Carrier for the pin snapshot handed from the memory clock domain
  to the test-clock domain.
  Assumes the word only changes on a rising test-clock edge.
*/
`timescale 1ns/1ps
interface bst_cap_if
#(
  parameter int unsigned W = 16
);
  // stable copy of the pin states, test-clock domain
  logic [W-1:0] word;

  modport src (output word);
  modport dst (input word);
endinterface : bst_cap_if

//--- core/bst_snap.sv
/*
  Pin snapshot crossing: samples the memory pins on clk and hands
  whole words to the test-clock domain by a toggle handshake.
  Assumes pin_state is synchronous to clk; tck may stop at any time,
  in which case the handshake simply waits.
*/
`timescale 1ns/1ps
module bst_snap
  import bst_pkg::*;
#(
  parameter int unsigned W = BST_BSR_LEN_DEF
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic tck,
  input wire logic [W-1:0] pin_state,
  bst_cap_if.src cap
);

  // ************************************************************
  // memory clock side
  // ************************************************************
  logic [W-1:0] hold;
  logic req_tog;
  logic ack_s1;
  logic ack_s2;
  logic ack_tog;

  // reload and toggle once the previous word was acknowledged
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold <= '0;
      req_tog <= 1'h0;
    end
    else if (ce && (ack_s2 == req_tog))
    begin
      hold <= pin_state;
      req_tog <= ~req_tog;
    end
  end

  // acknowledge toggle brought back into clk
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_s1 <= 1'h0;
      ack_s2 <= 1'h0;
    end
    else if (ce)
    begin
      ack_s1 <= ack_tog;
      ack_s2 <= ack_s1;
    end
  end

  // ************************************************************
  // test clock side
  // ************************************************************
  logic req_s1;
  logic req_s2;

  // request toggle brought into tck
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      req_s1 <= 1'h0;
      req_s2 <= 1'h0;
    end
    else
    begin
      req_s1 <= req_tog;
      req_s2 <= req_s1;
    end
  end

  // hold is stable while the toggles differ, so copy it whole
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      cap.word <= '0;
      ack_tog <= 1'h0;
    end
    else if (req_s2 != ack_tog)
    begin
      cap.word <= hold;
      ack_tog <= req_s2;
    end
  end

endmodule : bst_snap

//--- testbench/bst_tap_chk.sv
/*
  Pin-level checker for the test port, bound into bst_tap.
  Assumes tck edges never meet clk edges.
*/
`timescale 1ns/1ps
module bst_tap_chk
  import bst_pkg::*;
#(
  parameter int unsigned BSR_LEN = BST_BSR_LEN_DEF,
  parameter logic [BST_ID_LEN-1:0] ID_WORD = BST_ID_DEF
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [BSR_LEN-1:0] pin_state,
  input wire logic mem_hiz,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // **********
  // output timing, seen from the fast clock
  // **********
  a_tdo_fall_only: assert property (
    @(posedge clk) disable iff (!resetn)
    !$fell(tck) |-> $stable(tdo)) else $error("tdo moved off falling tck");
  a_oe_fall_only: assert property (
    @(posedge clk) disable iff (!resetn)
    !$fell(tck) |-> $stable(tdo_oe)) else $error("tdo_oe moved off falling");
  // frozen memory clock keeps the float request
  a_hiz_freeze: assert property (
    @(posedge clk) disable iff (!resetn)
    !ce |=> $stable(mem_hiz)) else $error("mem_hiz moved with ce low");
  // **********
  // state machine seen at the pins
  // **********
  a_oe_prior_low: assert property (
    @(posedge tck) disable iff (!resetn)
    tdo_oe |-> !$past(tms)) else $error("shift without low tms");
  a_oe_follow: assert property (
    @(posedge tck) disable iff (!resetn)
    tdo_oe |=> tdo_oe == !$past(tms)) else $error("shift exit wrong");
  a_oe_entry: assert property (
    @(posedge tck) disable iff (!resetn)
    $rose(tdo_oe) && !$past(tms, 2) |-> $past(tms, 3))
    else $error("shift entry wrong");
  // after idle, tms 1, 1, 0, 0 reaches instruction shift through capture
  a_ir_capture: assert property (
    @(posedge tck) disable iff (!resetn)
    $rose(tdo_oe) && !$past(tms, 2) && $past(tms, 3) && $past(tms, 4)
    && !$past(tms, 5) |-> tdo ##1 (!tdo_oe || !tdo))
    else $error("capture pattern wrong");
  a_reset_id: assert property (
    @(posedge tck) disable iff (!resetn)
    tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo_oe && tdo == ID_WORD[0])
    else $error("no identification after tap reset");
endmodule : bst_tap_chk

bind bst_tap bst_tap_chk #(.BSR_LEN(BSR_LEN), .ID_WORD(ID_WORD)) u_bst_tap_chk
(
  .clk(clk), .resetn(resetn), .ce(ce), .pin_state(pin_state),
  .mem_hiz(mem_hiz), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe)
);

//--- testbench/bst_tester.sv
/*
  Board test controller model: runs tck only inside frames.
  Assumes tdo_pin floats whenever the port does not drive it.
*/
`timescale 1ns/1ps
module bst_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_pin
);
  // idle: clock parked low, tms and tdi at pulled-up level
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one period: drive after falling, sample tdo before rising
  task automatic step(input logic m, input logic d, output logic q);
    #1 tms = m;
    tdi = d;
    #79 q = tdo_pin;
    tck = 1'b1;
    #80 tck = 1'b0;
  endtask : step

  // five high mode-select edges, then idle
  task automatic tap_reset();
    logic q;
    repeat (5)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : tap_reset

  // frame from idle through one register and back to idle
  task automatic scan(input logic ir, input int n,
    input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : bst_tester

//--- testbench/tb.sv
/*
  Testbench for bst_tap, scanning through the tester model.
  Assumes the tester clocks tck only within its tasks.
*/
`timescale 1ns/1ps
module tb;
  import bst_pkg::*;
  localparam int unsigned BLEN = 16;
  logic clk = 1'b0;
  logic resetn;
  logic ce;
  logic [BLEN-1:0] pin_state;
  logic mem_hiz;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic [31:0] got;
  wire tdo_pin;
  int fail_count = 0;
  int check_count = 0;

  // pad: tdo floats unless driven
  assign tdo_pin = tdo_oe ? tdo : 1'bz;
  // 200 MHz memory clock
  always #2.5 clk = ~clk;

  bst_tap #(.BSR_LEN(BLEN)) u_bst_tap
  (
    .clk(clk), .resetn(resetn), .ce(ce), .pin_state(pin_state),
    .mem_hiz(mem_hiz), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe)
  );
  bst_tester u_bst_tester
  (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin)
  );

  // **********
  // helpers
  // **********
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic g, input logic e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_bit

  task automatic scan(input logic ir, input int n, input logic [31:0] d);
    u_bst_tester.scan(ir, n, d, got);
  endtask : scan

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // **********
  // scenarios
  // **********
  // power-up: output off, identification word readable
  task automatic t_power_id();
    logic q;
    cmp_bit(tdo_pin, 1'bz);
    u_bst_tester.step(1'b0, 1'b1, q);
    scan(1'b0, 32, 32'h0);
    cmp_val(got, BST_ID_DEF);
    $display("t_power_id done");
  endtask : t_power_id

  // capture pattern, then one-bit bypass delay
  task automatic t_bypass();
    scan(1'b1, 3, {29'h0, BST_OP_BYPASS});
    cmp_val(got, {29'h0, BST_IR_CAPTURE});
    scan(1'b0, 8, 32'ha5);
    cmp_val(got, 32'h4a);
    cmp_bit(tdo_pin, 1'bz);
    $display("t_bypass done");
  endtask : t_bypass

  // reserved codes keep the chain one bit long
  task automatic t_reserved();
    logic [2:0] op [3] = '{BST_OP_RSVD_A, BST_OP_RSVD_B, BST_OP_RSVD_C};
    foreach (op[i])
    begin
      scan(1'b1, 3, {29'h0, op[i]});
      scan(1'b0, 4, 32'hb);
      cmp_val(got, 32'h6);
    end
    $display("t_reserved done");
  endtask : t_reserved

  // capture codes: pin word out, memory float per code
  task automatic t_sample();
    logic [2:0] op [3] = '{BST_OP_EXTEST, BST_OP_SAMPLE_Z, BST_OP_SAMPLE};
    foreach (op[i])
    begin
      scan(1'b1, 3, {29'h0, op[i]});
      scan(1'b0, BLEN, 32'h0);
      cmp_val(got, 32'(pin_state));
      cmp_bit(mem_hiz, op[i] != BST_OP_SAMPLE);
    end
    $display("t_sample done");
  endtask : t_sample

  // tester reset with memory clock frozen, then identification
  task automatic t_tap_reset();
    logic q;
    scan(1'b1, 3, {29'h0, BST_OP_SAMPLE_Z});
    // one idle edge lets the float level follow the new instruction
    u_bst_tester.step(1'b0, 1'b1, q);
    cmp_bit(mem_hiz, 1'b1);
    @(posedge clk);
    #1 ce = 1'b0;
    u_bst_tester.tap_reset();
    scan(1'b0, 32, 32'h0);
    cmp_bit(mem_hiz, 1'b1);
    @(posedge clk);
    #1 ce = 1'b1;
    repeat (10) @(posedge clk);
    cmp_bit(mem_hiz, 1'b0);
    cmp_val(got, BST_ID_DEF);
    $display("t_tap_reset done");
  endtask : t_tap_reset

  // pause halfway through an identification scan keeps every bit
  task automatic t_pause();
    logic q;
    logic [31:0] d;
    d = 32'h0;
    u_bst_tester.step(1'b1, 1'b1, q);
    u_bst_tester.step(1'b0, 1'b1, q);
    u_bst_tester.step(1'b0, 1'b1, q);
    for (int i = 0; i < 32; i++)
    begin
      u_bst_tester.step(i == 15 || i == 31, 1'b1, q);
      d[i] = q;
      if (i == 15)
      begin
        u_bst_tester.step(1'b0, 1'b1, q);
        u_bst_tester.step(1'b1, 1'b1, q);
        cmp_bit(q, 1'bz);
        u_bst_tester.step(1'b0, 1'b1, q);
      end
    end
    u_bst_tester.step(1'b1, 1'b1, q);
    u_bst_tester.step(1'b0, 1'b1, q);
    cmp_val(d, BST_ID_DEF);
    $display("t_pause done");
  endtask : t_pause

  // main sequence
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    pin_state = 16'hc3a5;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    t_power_id();
    t_bypass();
    t_reserved();
    t_sample();
    t_tap_reset();
    t_pause();
    test_done();
  end

  // watchdog
  initial
  begin
    #300000;
    fail_count++;
    test_done();
  end
endmodule : tb
